// [design/port_defs.svh]
// Purpose: constants for the two-port pin function control block
// Assumes: included by bare name from the package and the design modules
// Notes: register select = {register index, high-byte alias flag}
`ifndef PORT_DEFS_SVH
`define PORT_DEFS_SVH

// register indices
`define PPF_IDX_ANA_DATA 3'h0
`define PPF_IDX_ANA_DIR 3'h1
`define PPF_IDX_ADDR_DATA 3'h2
`define PPF_IDX_ADDR_DIR 3'h3
`define PPF_IDX_ADDR_FSEL 3'h4
`define PPF_IDX_ADDR_ALT 3'h5
`define PPF_IDX_ADDR_ALTE 3'h6
`define PPF_IDX_NONE 3'h7
`define PPF_NUM_REGS 7

// selects: bit 0 set means the high-byte alias
`define PPF_SEL_ANA_DATA_LOW 4'h0
`define PPF_SEL_ANA_DATA_HIGH 4'h1
`define PPF_SEL_ANA_DIR_LOW 4'h2
`define PPF_SEL_ANA_DIR_HIGH 4'h3
`define PPF_SEL_ADDR_DATA 4'h4
`define PPF_SEL_ADDR_DATA_HI 4'h5
`define PPF_SEL_ADDR_DIR 4'h6
`define PPF_SEL_ADDR_DIR_HI 4'h7
`define PPF_SEL_ADDR_FSEL 4'h8
`define PPF_SEL_ADDR_FSEL_HI 4'h9
`define PPF_SEL_ADDR_ALT 4'hA
`define PPF_SEL_ADDR_ALT_HI 4'hB
`define PPF_SEL_ADDR_ALTE 4'hC
`define PPF_SEL_ADDR_ALTE_HI 4'hD

// access sizes
`define PPF_SZ_BYTE 2'h0
`define PPF_SZ_BIT 2'h1
`define PPF_SZ_WORD 2'h2

// reset values, all-ones value and byte masks
`define PPF_RST_DIR 16'hFFFF
`define PPF_RST_ZERO 16'h0000
`define PPF_ALL_ONES 16'hFFFF
`define PPF_MASK_LO 16'h00FF
`define PPF_MASK_HI 16'hFF00

`endif

// [design/port_pkg.sv]
// Purpose: shared types of the pin function control block
// Assumes: port_defs.svh holds the numeric values
// Notes: none
`include "port_defs.svh"

package port_pkg;
   typedef enum logic [1:0]
   {
      SZ_BYTE = `PPF_SZ_BYTE,
      SZ_BIT = `PPF_SZ_BIT,
      SZ_WORD = `PPF_SZ_WORD
   } acc_size_e;
endpackage

// [design/reg16_if.sv]
// Purpose: write strobes, data and contents of one 16-bit port register
// Assumes: single clock domain
// Notes: ctl side drives strobes, store side holds the register
`timescale 1ns/1ns
`default_nettype none

interface reg16_if;
   logic wr_lo;
   logic wr_hi;
   logic [15:0] wdata;
   logic [15:0] q;
   modport ctl (output wr_lo, output wr_hi, output wdata, input q);
   modport store (input wr_lo, input wr_hi, input wdata, output q);
endinterface

`default_nettype wire

// [design/port_reg16.sv]
// Purpose: 16-bit port register with independent low and high byte strobes
// Assumes: strobes come from logic on sys_clk
// Notes: both strobes together form a word write
`timescale 1ns/1ns
`default_nettype none
`include "port_defs.svh"

module port_reg16 #(
   parameter logic [15:0] RST_VAL = `PPF_RST_ZERO
) (
   input wire logic sys_clk,
   input wire logic rst,
   reg16_if.store store
);
   logic [15:0] val_r;
   logic [15:0] val_nxt;

   always_comb
   begin
      val_nxt = val_r;
      if (store.wr_lo)
      begin
         val_nxt[7:0] = store.wdata[7:0]; // [R10]
      end
      if (store.wr_hi)
      begin
         val_nxt[15:8] = store.wdata[15:8]; // [R10]
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         val_r <= RST_VAL;
      end
      else
      begin
         val_r <= val_nxt;
      end
   end

   assign store.q = val_r;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_hi_byte_write;
      store.wr_hi && !store.wr_lo;
   endsequence

   sequence s_word_write;
      store.wr_hi && store.wr_lo;
   endsequence

   a_hi_byte_only: assert property ( // [R10]
      s_hi_byte_write |=> (((val_r ^ $past(val_r)) & `PPF_MASK_LO) == 16'h0000)
         && (((val_r ^ $past(store.wdata)) & `PPF_MASK_HI) == 16'h0000))
      else $error("high byte write disturbed low byte or missed high byte");

   a_word_whole: assert property ( // [R10]
      s_word_write |=> (val_r == $past(store.wdata)))
      else $error("word write did not update all sixteen bits");
endmodule

`default_nettype wire

// [design/port_pin_function_control.sv]
// Purpose: register and pin logic of an analog-shared port and an address-shared port
// Assumes: access port driven from sys_clk logic; pins are asynchronous
// Notes: high-byte aliases accept byte and bit access only
//
// Overview of operation
// R1 - software avoids analog data access during conversion
// R2 - software sets direction bit before analog use
// R3 - data high byte readable as alias low byte
// R4 - direction high byte reachable through its alias
// R5 - function select high byte through its alias
// R6 - alternate choice high byte through its alias
// R7 - extended choice high byte through its alias
// R8 - address mode needs one all-ones word write
// R9 - clear choice register before selecting address mode
// R10 - byte alias touches high byte; word all
// R11 - direction bit one turns pin driver off
`timescale 1ns/1ns
`default_nettype none
`include "port_defs.svh"

module port_pin_function_control (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic acc_wr,
   input wire logic acc_rd,
   input wire logic [3:0] acc_sel,
   input wire port_pkg::acc_size_e acc_size,
   input wire logic [2:0] acc_bit,
   input wire logic [15:0] acc_wdata,
   output logic [15:0] acc_rdata_r,
   input wire logic [15:0] analog_port_pin_in,
   output logic [15:0] analog_port_pin_out_r,
   output logic [15:0] analog_port_pin_oe_r,
   output logic [15:0] converter_input_pin_en_r,
   input wire logic [15:0] addr_port_pins_in,
   output logic [15:0] addr_port_pins_out_r,
   output logic [15:0] addr_port_pins_oe_r,
   input wire logic [15:0] external_address_lines,
   output logic separate_addr_mode_r
);
   reg16_if rif [`PPF_NUM_REGS] ();
   logic [15:0] q_all [`PPF_NUM_REGS];
   logic [15:0] src_all [`PPF_NUM_REGS];
   logic [`PPF_NUM_REGS-1:0] wr_lo_v;
   logic [`PPF_NUM_REGS-1:0] wr_hi_v;
   logic [15:0] wd;
   logic [15:0] cur;
   logic [15:0] rd_val;
   logic [3:0] bpos;
   logic [2:0] idx;
   logic hi;
   logic [15:0] ana_s1_r;
   logic [15:0] ana_s2_r;
   logic [15:0] addr_s1_r;
   logic [15:0] addr_s2_r;
   logic [15:0] ana_data_w;
   logic [15:0] ana_dir_w;
   logic [15:0] pdat_w;
   logic [15:0] dir_w;
   logic [15:0] fsel_w;
   logic [15:0] alt_w;
   logic [15:0] alte_w;
   logic [15:0] alt_addr;
   logic [15:0] acc_rdata_nxt;
   logic [15:0] ana_out_nxt;
   logic [15:0] ana_oe_nxt;
   logic [15:0] conv_en_nxt;
   logic [15:0] addr_out_nxt;
   logic [15:0] addr_oe_nxt;
   logic sep_mode_nxt;

   genvar g;
   generate
      for (g = 0; g < `PPF_NUM_REGS; g++)
      begin : g_reg
         port_reg16 #(
            .RST_VAL((g == `PPF_IDX_ANA_DIR || g == `PPF_IDX_ADDR_DIR) ?
                     `PPF_RST_DIR : `PPF_RST_ZERO)
         ) u_reg (
            .sys_clk(sys_clk),
            .rst(rst),
            .store(rif[g])
         );
         assign rif[g].wr_lo = wr_lo_v[g];
         assign rif[g].wr_hi = wr_hi_v[g];
         assign rif[g].wdata = wd;
         assign q_all[g] = rif[g].q;
      end
   endgenerate

   assign ana_data_w = q_all[`PPF_IDX_ANA_DATA];
   assign ana_dir_w = q_all[`PPF_IDX_ANA_DIR];
   assign pdat_w = q_all[`PPF_IDX_ADDR_DATA];
   assign dir_w = q_all[`PPF_IDX_ADDR_DIR];
   assign fsel_w = q_all[`PPF_IDX_ADDR_FSEL];
   assign alt_w = q_all[`PPF_IDX_ADDR_ALT];
   assign alte_w = q_all[`PPF_IDX_ADDR_ALTE];

   // pins in input or alternate mode read back the pin, else the output latch
   always_comb
   begin
      src_all = q_all;
      src_all[`PPF_IDX_ANA_DATA] = (ana_dir_w & ana_s2_r) | (~ana_dir_w & ana_data_w);
      src_all[`PPF_IDX_ADDR_DATA] = ((dir_w | fsel_w) & addr_s2_r)
                                  | (~(dir_w | fsel_w) & pdat_w);
   end

   // write path: word writes go to the base select only, aliases take bytes and bits
   always_comb
   begin
      idx = acc_sel[3:1];
      hi = acc_sel[0];
      bpos = {hi, acc_bit};
      wr_lo_v = '0;
      wr_hi_v = '0;
      cur = (idx == `PPF_IDX_NONE) ? `PPF_RST_ZERO : q_all[idx];
      wd = {acc_wdata[7:0], acc_wdata[7:0]};
      if (acc_wr && idx != `PPF_IDX_NONE)
      begin
         if (acc_size == port_pkg::SZ_WORD && !hi)
         begin
            wd = acc_wdata;
            wr_lo_v[idx] = 1'b1; // [R10]
            wr_hi_v[idx] = 1'b1; // [R10]
         end
         else if (acc_size == port_pkg::SZ_BYTE)
         begin
            wr_lo_v[idx] = !hi;
            wr_hi_v[idx] = hi; // [R3] [R4] [R5] [R6] [R7] [R10]
         end
         else if (acc_size == port_pkg::SZ_BIT)
         begin
            wd = cur;
            wd[bpos] = acc_wdata[0]; // [R3] [R4] [R5] [R6] [R7]
            wr_lo_v[idx] = !hi;
            wr_hi_v[idx] = hi;
         end
      end
   end

   // read path; the result holds until the next read
   always_comb
   begin
      rd_val = (idx == `PPF_IDX_NONE) ? `PPF_RST_ZERO : src_all[idx];
      acc_rdata_nxt = acc_rdata_r;
      if (acc_rd)
      begin
         if (idx == `PPF_IDX_NONE)
         begin
            acc_rdata_nxt = 16'h0000;
         end
         else if (acc_size == port_pkg::SZ_WORD && !hi)
         begin
            acc_rdata_nxt = rd_val;
         end
         else if (acc_size == port_pkg::SZ_BYTE)
         begin
            acc_rdata_nxt = hi ? (rd_val >> 8) : (rd_val & `PPF_MASK_LO); // [R3] [R4] [R5] [R6] [R7]
         end
         else if (acc_size == port_pkg::SZ_BIT)
         begin
            acc_rdata_nxt = {15'h0000, rd_val[bpos]};
         end
         else
         begin
            acc_rdata_nxt = 16'h0000;
         end
      end
   end

   // pin drive; the address select only reaches the pins when the choice bits are clear
   always_comb
   begin
      alt_addr = fsel_w & ~alt_w & ~alte_w;
      ana_out_nxt = ana_data_w;
      ana_oe_nxt = ~ana_dir_w; // [R11]
      conv_en_nxt = ana_dir_w; // [R2]
      addr_out_nxt = (alt_addr & external_address_lines) | (~fsel_w & pdat_w);
      addr_oe_nxt = ~dir_w & (~fsel_w | alt_addr); // [R11]
      sep_mode_nxt = (fsel_w == `PPF_ALL_ONES) && (alt_w == `PPF_RST_ZERO); // [R8] [R9]
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ana_s1_r <= 16'h0000;
         ana_s2_r <= 16'h0000;
         addr_s1_r <= 16'h0000;
         addr_s2_r <= 16'h0000;
      end
      else
      begin
         ana_s1_r <= analog_port_pin_in;
         ana_s2_r <= ana_s1_r;
         addr_s1_r <= addr_port_pins_in;
         addr_s2_r <= addr_s1_r;
      end
   end

   // analog data is not guarded against conversion; software keeps off it [R1]
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         acc_rdata_r <= 16'h0000;
         analog_port_pin_out_r <= 16'h0000;
         analog_port_pin_oe_r <= 16'h0000;
         converter_input_pin_en_r <= 16'h0000;
         addr_port_pins_out_r <= 16'h0000;
         addr_port_pins_oe_r <= 16'h0000;
         separate_addr_mode_r <= 1'b0;
      end
      else
      begin
         acc_rdata_r <= acc_rdata_nxt;
         analog_port_pin_out_r <= ana_out_nxt;
         analog_port_pin_oe_r <= ana_oe_nxt;
         converter_input_pin_en_r <= conv_en_nxt;
         addr_port_pins_out_r <= addr_out_nxt;
         addr_port_pins_oe_r <= addr_oe_nxt;
         separate_addr_mode_r <= sep_mode_nxt;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_alias_read(logic [3:0] sel);
      acc_rd && acc_sel == sel && acc_size == port_pkg::SZ_BYTE;
   endsequence

   a_data_alias_read: assert property ( // [R3]
      s_alias_read(`PPF_SEL_ADDR_DATA_HI) |=> acc_rdata_r == ($past(src_all[2]) >> 8))
      else $error("data alias read does not show data bits 15 to 8");

   a_dir_alias_read: assert property ( // [R4]
      s_alias_read(`PPF_SEL_ADDR_DIR_HI) |=> acc_rdata_r == ($past(dir_w) >> 8))
      else $error("direction alias read does not show bits 15 to 8");

   a_fsel_alias_read: assert property ( // [R5]
      s_alias_read(`PPF_SEL_ADDR_FSEL_HI) |=> acc_rdata_r == ($past(fsel_w) >> 8))
      else $error("function select alias read does not show bits 15 to 8");

   a_alt_alias_read: assert property ( // [R6]
      s_alias_read(`PPF_SEL_ADDR_ALT_HI) |=> acc_rdata_r == ($past(alt_w) >> 8))
      else $error("choice alias read does not show bits 15 to 8");

   a_alte_alias_write: assert property ( // [R7]
      acc_wr && acc_sel == `PPF_SEL_ADDR_ALTE_HI && acc_size == port_pkg::SZ_BYTE
      |=> alte_w == {$past(acc_wdata[7:0]), $past(alte_w[7:0])})
      else $error("extended choice alias write did not land in bits 15 to 8");

   a_addr_dir_off: assert property ( // [R11]
      ##1 (addr_port_pins_oe_r & $past(dir_w)) == 16'h0000)
      else $error("address port driver on while direction bit is one");

   a_ana_dir_off: assert property ( // [R11]
      ##1 (analog_port_pin_oe_r & $past(ana_dir_w)) == 16'h0000)
      else $error("analog port driver on while direction bit is one");

   a_dir_word_write: assert property ( // [R10]
      acc_wr && acc_sel == `PPF_SEL_ADDR_DIR && acc_size == port_pkg::SZ_WORD
      |=> dir_w == $past(acc_wdata) ##1 addr_port_pins_oe_r == (~$past(dir_w, 1)
         & (~$past(fsel_w) | $past(alt_addr))))
      else $error("direction word write not applied to all bits and pins");
endmodule

`default_nettype wire

// [verif/test_port_pin_function_control.sv]
// Purpose: self-checking bench for the two-port pin function control block
// Assumes: 20 MHz sys_clk; inputs change 5 ns after the rising edge
// Notes: random values from a fixed seed, with hand-made corner cases
`timescale 1ns/1ns
`default_nettype none
`include "port_defs.svh"

module test_port_pin_function_control;
   logic sys_clk;
   logic rst;
   logic acc_wr;
   logic acc_rd;
   logic [3:0] acc_sel;
   port_pkg::acc_size_e acc_size;
   logic [2:0] acc_bit;
   logic [15:0] acc_wdata;
   logic [15:0] acc_rdata_r;
   logic [15:0] ana_in;
   logic [15:0] ana_out;
   logic [15:0] ana_oe;
   logic [15:0] conv_en;
   logic [15:0] addr_in;
   logic [15:0] addr_out;
   logic [15:0] addr_oe;
   logic [15:0] ext_addr;
   logic sep_mode;
   int mismatches;
   int compares;
   int seed;
   logic [15:0] v;
   logic [15:0] w;
   logic [7:0] b;
   logic [3:0] s;
   logic [3:0] k;
   logic [3:0] sel_list [7];

   port_pin_function_control i_dut (
      .sys_clk(sys_clk), .rst(rst), .acc_wr(acc_wr), .acc_rd(acc_rd),
      .acc_sel(acc_sel), .acc_size(acc_size), .acc_bit(acc_bit),
      .acc_wdata(acc_wdata), .acc_rdata_r(acc_rdata_r),
      .analog_port_pin_in(ana_in), .analog_port_pin_out_r(ana_out),
      .analog_port_pin_oe_r(ana_oe), .converter_input_pin_en_r(conv_en),
      .addr_port_pins_in(addr_in), .addr_port_pins_out_r(addr_out),
      .addr_port_pins_oe_r(addr_oe), .external_address_lines(ext_addr),
      .separate_addr_mode_r(sep_mode)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   function automatic logic [15:0] put_hi(input logic [15:0] old, input logic [7:0] hb);
      put_hi = {hb, old[7:0]};
   endfunction

   function automatic logic [15:0] put_bit(input logic [15:0] old, input logic [3:0] n);
      put_bit = old ^ (16'h0001 << n);
   endfunction

   task automatic report_and_stop();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check16(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // an idle cycle before each access keeps the strobe from being set twice at one step
   task automatic wr(input logic [3:0] sel, input port_pkg::acc_size_e sz,
                     input logic [2:0] bt, input logic [15:0] d);
      @(posedge sys_clk);
      #5;
      acc_sel = sel;
      acc_size = sz;
      acc_bit = bt;
      acc_wdata = d;
      acc_wr = 1'b1;
      @(posedge sys_clk);
      #5;
      acc_wr = 1'b0;
   endtask

   task automatic rd(input logic [3:0] sel, input port_pkg::acc_size_e sz,
                     output logic [15:0] q);
      @(posedge sys_clk);
      #5;
      acc_sel = sel;
      acc_size = sz;
      acc_rd = 1'b1;
      @(posedge sys_clk);
      #5;
      acc_rd = 1'b0;
      q = acc_rdata_r;
   endtask

   // a hang ends the run through the same report
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      report_and_stop();
   end

   initial
   begin
      seed = 32'h70F8;
      mismatches = 0;
      compares = 0;
      rst = 1'b1;
      acc_wr = 1'b0;
      acc_rd = 1'b0;
      acc_sel = 4'h0;
      acc_size = port_pkg::SZ_WORD;
      acc_bit = 3'h0;
      acc_wdata = 16'h0000;
      ana_in = 16'($random(seed));
      addr_in = 16'($random(seed));
      ext_addr = 16'($random(seed));
      sel_list = '{`PPF_SEL_ANA_DATA_LOW, `PPF_SEL_ADDR_DATA, `PPF_SEL_ADDR_FSEL,
                   `PPF_SEL_ADDR_ALT, `PPF_SEL_ADDR_ALTE, `PPF_SEL_ANA_DIR_LOW,
                   `PPF_SEL_ADDR_DIR};
      repeat (3) @(posedge sys_clk);
      #5;
      rst = 1'b0;
      @(posedge sys_clk);
      #5;
      check16("conv_en", 16'hFFFF, conv_en);
      check16("ana_oe", 16'h0000, ana_oe);
      rd(`PPF_SEL_ADDR_DIR, port_pkg::SZ_WORD, w);
      check16("addr_dir", 16'hFFFF, w);
      // input mode reads the pins, not the latch
      rd(`PPF_SEL_ANA_DATA_LOW, port_pkg::SZ_WORD, w); // no conversion runs in this bench
      check16("ana_pins", ana_in, w);
      wr(`PPF_SEL_ANA_DIR_LOW, port_pkg::SZ_WORD, 3'h0, 16'h0000);
      wr(`PPF_SEL_ADDR_DIR, port_pkg::SZ_WORD, 3'h0, 16'h0000);
      repeat (2) @(posedge sys_clk);
      #5;
      check16("ana_oe", 16'hFFFF, ana_oe);
      check16("addr_oe", 16'hFFFF, addr_oe);
      for (int i = 0; i < 7; i++)
      begin
         s = sel_list[i];
         v = 16'($random(seed));
         wr(s, port_pkg::SZ_WORD, 3'h0, v);
         rd(s | 4'h1, port_pkg::SZ_BYTE, w);
         check16("alias_rd", {8'h00, v[15:8]}, w);
         b = 8'($random(seed));
         wr(s | 4'h1, port_pkg::SZ_BYTE, 3'h0, {8'h00, b});
         v = put_hi(v, b);
         rd(s, port_pkg::SZ_WORD, w);
         check16("alias_wr", v, w);
         b = 8'($random(seed));
         wr(s, port_pkg::SZ_BYTE, 3'h0, {8'h00, b});
         v = {v[15:8], b};
         k = 4'h8 + 4'($unsigned($random(seed)) % 8);
         wr(s | 4'h1, port_pkg::SZ_BIT, k[2:0], {15'h0000, ~v[k]});
         v = put_bit(v, k);
         // a word on the alias is refused and must leave the register alone
         wr(s | 4'h1, port_pkg::SZ_WORD, 3'h0, ~v);
         rd(s, port_pkg::SZ_WORD, w);
         check16("bit_wr", v, w);
         if (s == `PPF_SEL_ANA_DATA_LOW)
            check16("ana_out", v, ana_out);
         if (s == `PPF_SEL_ANA_DIR_LOW)
         begin
            check16("ana_oe", ~v, ana_oe);
            check16("conv_en", v, conv_en);
         end
      end
      wr(4'hE, port_pkg::SZ_WORD, 3'h0, 16'hFFFF);
      rd(4'hE, port_pkg::SZ_WORD, w);
      check16("unmapped", 16'h0000, w);
      // address mode: choice cleared first, then one all-ones word
      wr(`PPF_SEL_ADDR_DIR, port_pkg::SZ_WORD, 3'h0, 16'h0000);
      wr(`PPF_SEL_ADDR_ALTE, port_pkg::SZ_WORD, 3'h0, 16'h0000);
      wr(`PPF_SEL_ADDR_ALT, port_pkg::SZ_WORD, 3'h0, 16'h0000);
      wr(`PPF_SEL_ADDR_FSEL, port_pkg::SZ_WORD, 3'h0, 16'hFFFF);
      repeat (2) @(posedge sys_clk);
      #5;
      ext_addr = 16'($random(seed));
      repeat (2) @(posedge sys_clk);
      #5;
      check16("sep_mode", 16'h0001, {15'h0000, sep_mode});
      check16("addr_oe", 16'hFFFF, addr_oe);
      check16("addr_out", ext_addr, addr_out);
      wr(`PPF_SEL_ADDR_ALT, port_pkg::SZ_WORD, 3'h0, 16'h0001);
      repeat (2) @(posedge sys_clk);
      #5;
      check16("sep_mode", 16'h0000, {15'h0000, sep_mode});
      check16("addr_oe", 16'hFFFE, addr_oe);
      // direction one turns the driver off even on a pin that drives the address
      wr(`PPF_SEL_ADDR_DIR_HI, port_pkg::SZ_BIT, 3'h7, 16'h0001);
      repeat (2) @(posedge sys_clk);
      #5;
      check16("addr_oe", 16'h7FFE, addr_oe);
      // bit read through the alias: bit 7 of the alias is direction bit 15
      acc_bit = 3'h7;
      rd(`PPF_SEL_ADDR_DIR_HI, port_pkg::SZ_BIT, w);
      check16("bit_rd", 16'h0001, w);
      // the spare size code is refused and reads zero
      rd(`PPF_SEL_ADDR_DIR, port_pkg::acc_size_e'(2'h3), w);
      check16("bad_size", 16'h0000, w);
      // every pin in alternate mode reads back its synchronised level
      rd(`PPF_SEL_ADDR_DATA, port_pkg::SZ_WORD, w);
      check16("addr_pins", addr_in, w);
      report_and_stop();
   end
endmodule

`default_nettype wire
